/* File: pkg/vgc_pkg.sv */
/*
  Constants for the legacy graphics controller datapath: I/O ports, register
  indices, field positions, reset values, window bases and operation codes.
  Assumes a 16-bit legacy I/O space and a 20-bit host memory address.
*/
// Functional notes
// [RULE1] Index port selects which internal register the data port reaches.
// [RULE2] Set/reset value holds one constant bit per display map.
// [RULE3] Set/reset enable per map substitutes that constant for host data.
// [RULE4] Pixel read compares each latched 4-bit pixel with compare color.
// [RULE5] Maps whose don't-care bit is zero are left out of compare.
// [RULE6] Host data rotates right by count, only in write modes 0 and 3.
// [RULE7] Function select: replace, AND, OR or XOR with latched data.
// [RULE8] Bit mask after the function chooses which bits get updated.
// [RULE9] Every host read loads latches; byte read returns selected map's latch. Code loads them only on reads inside the window.
// [RULE10] Two-bit field picks write mode 0 to 3.
// [RULE11] Read mode bit: 0 byte oriented, 1 color compare.
// [RULE12] Odd/even bit enables legacy odd/even addressing.
// [RULE13] Shift mode bit: 0 linear, 1 tiled shift register loading.
// [RULE14] 256-color bit selects packed pixel loading and overrides shift mode.
// [RULE15] Graphics bit selects graphics mode; chain bit chains odd maps to even.
// [RULE16] Window field: A0000 128K, A0000 64K, B0000 32K, B8000 32K.
// [RULE17] Write mode 0 replaces rotated byte by set/reset where enabled.
// [RULE18] Unimplemented index reads zero and ignores writes.
package vgc_pkg;
  localparam logic [15:0] IO_INDEX_PORT = 16'h03ce;
  localparam logic [15:0] IO_DATA_PORT = 16'h03cf;

  localparam logic [3:0] IDX_SET_RESET_VALUE = 4'h0;
  localparam logic [3:0] IDX_SET_RESET_ENABLE = 4'h1;
  localparam logic [3:0] IDX_COLOR_COMPARE = 4'h2;
  localparam logic [3:0] IDX_DATA_ROTATE_FUNCTION = 4'h3;
  localparam logic [3:0] IDX_READ_MAP_SELECT = 4'h4;
  localparam logic [3:0] IDX_GRAPHICS_MODE = 4'h5;
  localparam logic [3:0] IDX_GRAPHICS_MISC = 4'h6;
  localparam logic [3:0] IDX_COLOR_DONT_CARE = 4'h7;
  localparam logic [3:0] IDX_WRITE_BIT_MASK = 4'h8;

  // Writable bits per register; reserved bits store and read zero
  localparam logic [7:0] MASK_NIBBLE = 8'h0f;
  localparam logic [7:0] MASK_ROTATE_FUNCTION = 8'h1f;
  localparam logic [7:0] MASK_READ_MAP = 8'h03;
  localparam logic [7:0] MASK_MODE = 8'h7b;
  localparam logic [7:0] MASK_FULL = 8'hff;
  localparam logic [7:0] REG_RESET = 8'h00;

  localparam int ROT_LSB = 0;
  localparam int FN_LSB = 3;
  localparam int WMODE_LSB = 0;
  localparam int RMODE_BIT = 3;
  localparam int ODD_EVEN_BIT = 4;
  localparam int SHIFT_BIT = 5;
  localparam int PACK_BIT = 6;
  localparam int GFX_BIT = 0;
  localparam int CHAIN_BIT = 1;
  localparam int WIN_LSB = 2;

  localparam logic [1:0] FN_REPLACE = 2'h0;
  localparam logic [1:0] FN_AND = 2'h1;
  localparam logic [1:0] FN_OR = 2'h2;
  localparam logic [1:0] FN_XOR = 2'h3;

  localparam logic [1:0] WMODE_0 = 2'h0;
  localparam logic [1:0] WMODE_1 = 2'h1;
  localparam logic [1:0] WMODE_2 = 2'h2;
  localparam logic [1:0] WMODE_3 = 2'h3;

  localparam logic [1:0] SHIFT_LINEAR = 2'h0;
  localparam logic [1:0] SHIFT_TILED = 2'h1;
  localparam logic [1:0] SHIFT_PACKED = 2'h2;

  localparam logic [1:0] WIN_A0000_128K = 2'h0;
  localparam logic [1:0] WIN_A0000_64K = 2'h1;
  localparam logic [1:0] WIN_B0000_32K = 2'h2;
  localparam logic [1:0] WIN_B8000_32K = 2'h3;
  localparam logic [19:0] BASE_A0000 = 20'ha0000;
  localparam logic [19:0] BASE_B0000 = 20'hb0000;
  localparam logic [19:0] BASE_B8000 = 20'hb8000;
  localparam logic [19:0] SIZE_128K = 20'h20000;
  localparam logic [19:0] SIZE_64K = 20'h10000;
  localparam logic [19:0] SIZE_32K = 20'h08000;

  localparam logic [7:0] OUTSIDE_READ_DATA = 8'hff;
  localparam int NUM_MAPS = 4;
endpackage

/* File: verification/vgc_graphics_controller_sva.sv */
/*
  Port checks of controller handshakes and decodes.
  Assumes requests stay low during reset.
*/
`timescale 1ns/100ps
`default_nettype none
module vgc_graphics_controller_sva #(
  parameter int ADDR_W = 16
) (
  input wire logic sys_clk_in,
  input wire logic arst_n_in,
  input wire logic [15:0] io_addr_in,
  input wire logic io_rd_in,
  input wire logic [7:0] io_rdata_out,
  input wire logic io_rvalid_out,
  input wire logic [19:0] mem_addr_in,
  input wire logic mem_wr_in,
  input wire logic mem_rd_in,
  input wire logic [7:0] mem_rdata_out,
  input wire logic mem_rvalid_out,
  input wire logic mem_busy_out,
  input wire logic map_rd_out,
  input wire logic map_wr_out,
  input wire logic [ADDR_W-1:0] map_addr_out,
  input wire logic [3:0] map_wen_out,
  input wire logic map_rvalid_in,
  input wire logic chain_odd_to_even_out,
  input wire logic legacy_odd_even_enable_out,
  input wire logic [1:0] shift_load_mode_out,
  input wire logic [1:0] memory_window_select_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!arst_n_in);
  logic take, low_win;
  assign take = !mem_busy_out && !mem_wr_in && mem_rd_in;
  assign low_win = memory_window_select_out == vgc_pkg::WIN_A0000_128K && mem_addr_in[19:17] == 3'b101;
  property p_io_answer;
    io_rvalid_out == $past(io_rd_in && (io_addr_in == vgc_pkg::IO_INDEX_PORT || io_addr_in == vgc_pkg::IO_DATA_PORT));
  endproperty
  a_io_answer: assert property (p_io_answer) else $error("io answer pulse wrong");
  property p_index_read;
    io_rd_in && io_addr_in == vgc_pkg::IO_INDEX_PORT |=> io_rdata_out[7:4] == 4'h0;
  endproperty
  a_index_read: assert property (p_index_read) else $error("index read upper bits set");
  property p_map_read;
    take && low_win && !legacy_odd_even_enable_out && !chain_odd_to_even_out
      |=> map_rd_out && mem_busy_out && map_addr_out == $past(mem_addr_in[ADDR_W-1:0]);
  endproperty
  a_map_read: assert property (p_map_read) else $error("map read not issued");
  property p_read_done;
    mem_busy_out && map_rvalid_in |=> mem_rvalid_out && !mem_busy_out;
  endproperty
  a_read_done: assert property (p_read_done) else $error("read answer missing");
  property p_busy_end;
    $rose(mem_busy_out) |-> ##[1:40] !mem_busy_out;
  endproperty
  a_busy_end: assert property (p_busy_end) else $error("busy stuck");
  property p_busy_no_write;
    mem_busy_out |-> !map_wr_out;
  endproperty
  a_busy_no_write: assert property (p_busy_no_write) else $error("write while busy");
  property p_write;
    mem_wr_in && !mem_busy_out && low_win |=> map_wr_out;
  endproperty
  a_write: assert property (p_write) else $error("map write missing");
  property p_outside;
    take && memory_window_select_out == vgc_pkg::WIN_B8000_32K && mem_addr_in[19:15] != 5'h17
      |=> mem_rvalid_out && !map_rd_out && mem_rdata_out == vgc_pkg::OUTSIDE_READ_DATA;
  endproperty
  a_outside: assert property (p_outside) else $error("outside read wrong");
  property p_odd_even;
    mem_wr_in && !mem_busy_out && low_win && legacy_odd_even_enable_out
      |=> !map_addr_out[0] && map_wen_out == ($past(mem_addr_in[0]) ? 4'ha : 4'h5);
  endproperty
  a_odd_even: assert property (p_odd_even) else $error("odd even write wrong");
  property p_shift;
    shift_load_mode_out != 2'h3;
  endproperty
  a_shift: assert property (p_shift) else $error("shift mode code illegal");
  c_read: cover property (mem_busy_out && map_rvalid_in);
  c_odd_even: cover property (map_wr_out && legacy_odd_even_enable_out);
  c_outside: cover property (mem_rvalid_out && !$past(mem_busy_out));
endmodule
bind vgc_graphics_controller vgc_graphics_controller_sva #(.ADDR_W(ADDR_W)) u_vgc_graphics_controller_sva (.*);
`default_nettype wire

/* File: verification/vgc_graphics_controller_tb_top.sv */
/*
  Bench: registers, write path, read path, odd/even, windows.
  Assumes a preloaded map model with a set read delay.
*/
`timescale 1ns/100ps
`default_nettype none
module vgc_graphics_controller_tb_top;
  localparam logic [7:0] HOST = 8'h96;
  localparam logic [2:0] ROT = 3'h3;
  localparam logic [3:0] SR = 4'h3;
  localparam logic [3:0] SRE = 4'h5;
  localparam logic [7:0] MASK = 8'hf0;
  logic sys_clk_in, arst_n_in, io_wr_in, io_rd_in, io_rvalid_out, mem_wr_in, mem_rd_in;
  logic mem_rvalid_out, mem_busy_out, map_rd_out, map_wr_out, map_rvalid_in, gfx, chain, odd_even;
  logic [15:0] io_addr_in, map_addr_out;
  logic [19:0] mem_addr_in;
  logic [7:0] io_wdata_in, io_rdata_out, mem_wdata_in, mem_rdata_out, v;
  logic [31:0] map_wdata_out, map_rdata_in, lat;
  logic [3:0] map_wen_out, dly;
  logic [1:0] shift, win;
  logic [7:0] rmask [10] = '{8'h0f, 8'h0f, 8'h0f, 8'h1f, 8'h03, 8'h7b, 8'h0f, 8'h0f, 8'hff, 8'h00};
  logic [19:0] inb [4] = '{20'ha0000, 20'ha0000, 20'hb0000, 20'hb8000};
  logic [19:0] outb [4] = '{20'hc0000, 20'hb0000, 20'hb8000, 20'ha0000};
  logic [3:0] dcs [4] = '{4'h0, 4'h5, 4'hf, 4'h9};
  int err_count, tests_run, cycles;
  vgc_graphics_controller u_vgc_graphics_controller (.*,
    .graphics_mode_select_out(gfx), .chain_odd_to_even_out(chain), .legacy_odd_even_enable_out(odd_even),
    .shift_load_mode_out(shift), .memory_window_select_out(win));
  vgc_map_model u_vgc_map_model (.sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in), .map_rd_in(map_rd_out),
    .map_wr_in(map_wr_out), .map_addr_in(map_addr_out), .map_wen_in(map_wen_out), .map_wdata_in(map_wdata_out),
    .dly_in(dly), .map_rdata_out(map_rdata_in), .map_rvalid_out(map_rvalid_in));
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      err_count++;
      $display("BAD %s exp %h seen %h", n, exp, seen);
    end
  endtask
  task automatic test_done;
    $display("errors %0d checks %0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic io_acc(input logic wr, input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk_in);
    io_addr_in <= a;
    io_wdata_in <= d;
    io_wr_in <= wr;
    io_rd_in <= !wr;
    @(posedge sys_clk_in);
    io_wr_in <= 1'b0;
    io_rd_in <= 1'b0;
    #1;
  endtask
  task automatic reg_wr(input logic [3:0] i, input logic [7:0] d);
    io_acc(1'b1, vgc_pkg::IO_INDEX_PORT, {4'h0, i});
    io_acc(1'b1, vgc_pkg::IO_DATA_PORT, d);
  endtask
  task automatic reg_rd(input logic [3:0] i, output logic [7:0] d);
    io_acc(1'b1, vgc_pkg::IO_INDEX_PORT, {4'h0, i});
    io_acc(1'b0, vgc_pkg::IO_DATA_PORT, 8'h00);
    chk("io_rvalid", io_rvalid_out, 1'b1);
    d = io_rdata_out;
  endtask
  task automatic mem_acc(input logic wr, input logic [19:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge sys_clk_in);
    mem_addr_in <= a;
    mem_wdata_in <= d;
    mem_wr_in <= wr;
    mem_rd_in <= !wr;
    @(posedge sys_clk_in);
    mem_wr_in <= 1'b0;
    mem_rd_in <= 1'b0;
    repeat (30)
    begin
      #1;
      if (wr || mem_rvalid_out === 1'b1)
        break;
      @(posedge sys_clk_in);
    end
    chk("mem_answer", wr ? map_wr_out : mem_rvalid_out, 1'b1);
    q = mem_rdata_out;
  endtask
  function automatic logic [7:0] exp_wr(input int i, input logic [1:0] wm, input logic [1:0] fn);
    logic [7:0] rt, src, msk, l, f;
    l = lat[8*i+:8];
    rt = (HOST >> ROT) | (HOST << (4'h8 - ROT));
    src = (wm == 2'h0 && SRE[i]) ? {8{SR[i]}} : (wm == 2'h2) ? {8{HOST[i]}} : (wm == 2'h3) ? {8{SR[i]}} : rt;
    msk = (wm == 2'h3) ? (MASK & rt) : MASK;
    f = (fn == 2'h1) ? (src & l) : (fn == 2'h2) ? (src | l) : (fn == 2'h3) ? (src ^ l) : src;
    exp_wr = (wm == 2'h1) ? l : ((f & msk) | (l & ~msk));
  endfunction
  function automatic logic [7:0] exp_cc(input logic [3:0] dc);
    exp_cc = 8'hff;
    for (int b = 0; b < 8; b++)
      for (int i = 0; i < 4; i++)
        if (dc[i] && lat[8*i+b] != 1'(4'ha >> i))
          exp_cc[b] = 1'b0;
  endfunction
  initial
  begin
    sys_clk_in = 1'b0;
    forever #2 sys_clk_in = ~sys_clk_in;
  end
  // Ceiling far above the run length
  always @(posedge sys_clk_in)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_count++;
      test_done();
    end
  end
  initial
  begin
    {arst_n_in, io_wr_in, io_rd_in, mem_wr_in, mem_rd_in} = 5'h0;
    {io_addr_in, io_wdata_in, mem_addr_in, mem_wdata_in, dly} = 56'h0;
    repeat (20) @(posedge sys_clk_in);
    arst_n_in <= 1'b1;
    for (int i = 0; i < 10; i++)
    begin
      reg_rd(i[3:0], v);
      chk("reset_val", v, 8'h00);
      reg_wr(i[3:0], 8'hff);
      reg_rd(i[3:0], v);
      chk("reg_bits", v, rmask[i]);
      io_acc(1'b0, vgc_pkg::IO_INDEX_PORT, 8'h00);
      chk("index", io_rdata_out, {4'h0, i[3:0]});
    end
    chk("mode_out", {gfx, chain, odd_even, shift, win}, 7'h7b);
    reg_wr(4'h5, 8'h20);
    chk("tiled", shift, 2'h1);
    reg_wr(4'h5, 8'h00);
    chk("linear", shift, 2'h0);
    reg_wr(4'h6, 8'h01);
    lat = u_vgc_map_model.mem[5];
    for (int m = 0; m < 4; m++)
    begin
      dly <= 4'(2 * m);
      reg_wr(4'(m), 8'(m));
      reg_wr(4'h4, 8'(m));
      mem_acc(1'b0, 20'ha0005, 8'h00, v);
      chk("byte_read", v, lat[8*m+:8]);
    end
    reg_wr(4'h0, {4'h0, SR});
    reg_wr(4'h1, {4'h0, SRE});
    reg_wr(4'h8, MASK);
    for (int k = 0; k < 16; k++)
    begin
      reg_wr(4'h3, {3'h0, 2'(k), ROT});
      reg_wr(4'h5, {6'h0, 2'(k >> 2)});
      mem_acc(1'b1, 20'ha0010, HOST, v);
      for (int i = 0; i < 4; i++)
        chk("wdata", map_wdata_out[8*i+:8], exp_wr(i, 2'(k >> 2), 2'(k)));
    end
    reg_wr(4'h5, 8'h08);
    reg_wr(4'h2, 8'h0a);
    for (int j = 0; j < 4; j++)
    begin
      reg_wr(4'h7, {4'h0, dcs[j]});
      mem_acc(1'b0, 20'ha0005, 8'h00, v);
      chk("compare", v, exp_cc(dcs[j]));
    end
    reg_wr(4'h5, 8'h10);
    mem_acc(1'b1, 20'ha0007, 8'h5a, v);
    chk("oe_addr", {map_addr_out, map_wen_out}, 20'h0006a);
    reg_wr(4'h5, 8'h00);
    for (int w = 0; w < 4; w++)
    begin
      reg_wr(4'h6, {4'h0, 2'(w), 2'h1});
      mem_acc(1'b0, inb[w] + 20'h13, 8'h00, v);
      chk("win_addr", map_addr_out, 16'h0013);
      mem_acc(1'b0, outb[w], 8'h00, v);
      chk("win_out", v, 8'hff);
    end
    test_done();
  end
endmodule
`default_nettype wire

/* File: verification/vgc_map_model.sv */
/*
  Model of the four display maps.
  Assumes one request per cycle; a read answers dly_in+2 cycles after map_rd_in.
*/
`timescale 1ns/100ps
`default_nettype none
module vgc_map_model (
  input wire logic sys_clk_in,
  input wire logic arst_n_in,
  input wire logic map_rd_in,
  input wire logic map_wr_in,
  input wire logic [15:0] map_addr_in,
  input wire logic [3:0] map_wen_in,
  input wire logic [31:0] map_wdata_in,
  input wire logic [3:0] dly_in,
  output logic [31:0] map_rdata_out,
  output logic map_rvalid_out
);
  logic [31:0] mem [256];
  logic [3:0] cnt;
  logic [7:0] pa;
  initial
  begin
    for (int a = 0; a < 256; a++)
      mem[a] = {a[7:0] ^ 8'h96, a[7:0] + 8'h21, ~a[7:0], a[7:0] ^ 8'h3c};
  end
  always_ff @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      cnt <= 4'h0;
      map_rvalid_out <= 1'b0;
      map_rdata_out <= 32'h0;
    end
    else
    begin
      // Data is only good with the valid pulse, so it toggles otherwise
      map_rvalid_out <= (cnt == 4'h1);
      map_rdata_out <= (cnt == 4'h1) ? mem[pa] : ~map_rdata_out;
      if (map_rd_in)
      begin
        cnt <= dly_in + 4'h1;
        pa <= map_addr_in[7:0];
      end
      else if (cnt != 4'h0)
        cnt <= cnt - 4'h1;
      for (int i = 0; i < 4; i++)
        if (map_wr_in && map_wen_in[i])
          mem[map_addr_in[7:0]][8*i+:8] <= map_wdata_in[8*i+:8];
    end
  end
endmodule
`default_nettype wire

/* File: verilog/vgc_graphics_controller.sv */
/*
  Graphics controller datapath: indexed register file behind the legacy I/O
  port pair, host write path (set/reset, rotate, logical function, bit mask)
  and host read path (latched byte or color compare).
  Assumes display maps answer a read with map_rvalid_in some cycles after
  map_rd_out, and accept a write in the cycle of map_wr_out.
*/
`timescale 1ns/100ps
`default_nettype none
module vgc_graphics_controller #(
  parameter int ADDR_W = 16
) (
  input wire logic sys_clk_in,
  input wire logic arst_n_in,
  input wire logic [15:0] io_addr_in,
  input wire logic io_wr_in,
  input wire logic io_rd_in,
  input wire logic [7:0] io_wdata_in,
  output logic [7:0] io_rdata_out,
  output logic io_rvalid_out,
  input wire logic [19:0] mem_addr_in,
  input wire logic mem_wr_in,
  input wire logic mem_rd_in,
  input wire logic [7:0] mem_wdata_in,
  output logic [7:0] mem_rdata_out,
  output logic mem_rvalid_out,
  output logic mem_busy_out,
  output logic map_rd_out,
  output logic map_wr_out,
  output logic [ADDR_W-1:0] map_addr_out,
  output logic [3:0] map_wen_out,
  output logic [31:0] map_wdata_out,
  input wire logic [31:0] map_rdata_in,
  input wire logic map_rvalid_in,
  output logic graphics_mode_select_out,
  output logic chain_odd_to_even_out,
  output logic legacy_odd_even_enable_out,
  output logic [1:0] shift_load_mode_out,
  output logic [1:0] memory_window_select_out
);
  typedef enum logic {ST_IDLE, ST_READ_WAIT} vgc_phase_t;

  typedef struct packed {
    vgc_phase_t phase;
    logic [3:0] register_pointer;
    logic [7:0] set_reset_value;
    logic [7:0] set_reset_enable;
    logic [7:0] color_compare;
    logic [7:0] data_rotate_function;
    logic [7:0] read_map_select;
    logic [7:0] graphics_mode;
    logic [7:0] graphics_misc;
    logic [7:0] color_dont_care;
    logic [7:0] write_bit_mask;
    logic [7:0] io_rdata;
    logic io_rvalid;
    logic [7:0] mem_rdata;
    logic mem_rvalid;
    logic busy;
    logic odd_pending;
    logic map_rd;
    logic map_wr;
    logic [ADDR_W-1:0] map_addr;
    logic [3:0] map_wen;
    logic [31:0] map_wdata;
    logic [1:0] shift_mode;
  } vgc_state_t;

  vgc_state_t cur;
  vgc_state_t next_cur;
  logic [31:0] latch_q;
  logic latch_load;

  function automatic logic [7:0] rotate_right(input logic [7:0] d, input logic [2:0] n);
    logic [15:0] dbl;
    dbl = {d, d} >> n;
    return dbl[7:0];
  endfunction

  function automatic logic [7:0] logic_unit(input logic [7:0] d, input logic [7:0] l, input logic [1:0] fn);
    logic [7:0] r;
    r = d;
    case (fn)
      vgc_pkg::FN_AND: r = d & l;
      vgc_pkg::FN_OR: r = d | l;
      vgc_pkg::FN_XOR: r = d ^ l;
      default: r = d;
    endcase
    return r;
  endfunction

  // Hit flag above window offset
  function automatic logic [17:0] window_decode(input logic [19:0] a, input logic [1:0] sel);
    logic [19:0] base;
    logic [19:0] size;
    logic [19:0] off;
    base = vgc_pkg::BASE_A0000;
    size = vgc_pkg::SIZE_128K;
    case (sel)
      vgc_pkg::WIN_A0000_64K:
      begin
        size = vgc_pkg::SIZE_64K;
      end
      vgc_pkg::WIN_B0000_32K:
      begin
        base = vgc_pkg::BASE_B0000;
        size = vgc_pkg::SIZE_32K;
      end
      vgc_pkg::WIN_B8000_32K:
      begin
        base = vgc_pkg::BASE_B8000;
        size = vgc_pkg::SIZE_32K;
      end
      default:
      begin
        size = vgc_pkg::SIZE_128K;
      end
    endcase
    off = a - base;
    return {(a >= base) && (off < size), off[16:0]};
  endfunction

  function automatic logic [7:0] reg_read(input vgc_state_t s);
    logic [7:0] r;
    r = 8'h00;
    if (s.register_pointer == vgc_pkg::IDX_SET_RESET_VALUE)
      r = s.set_reset_value;
    else if (s.register_pointer == vgc_pkg::IDX_SET_RESET_ENABLE)
      r = s.set_reset_enable;
    else if (s.register_pointer == vgc_pkg::IDX_COLOR_COMPARE)
      r = s.color_compare;
    else if (s.register_pointer == vgc_pkg::IDX_DATA_ROTATE_FUNCTION)
      r = s.data_rotate_function;
    else if (s.register_pointer == vgc_pkg::IDX_READ_MAP_SELECT)
      r = s.read_map_select;
    else if (s.register_pointer == vgc_pkg::IDX_GRAPHICS_MODE)
      r = s.graphics_mode;
    else if (s.register_pointer == vgc_pkg::IDX_GRAPHICS_MISC)
      r = s.graphics_misc;
    else if (s.register_pointer == vgc_pkg::IDX_COLOR_DONT_CARE)
      r = s.color_dont_care;
    else if (s.register_pointer == vgc_pkg::IDX_WRITE_BIT_MASK)
      r = s.write_bit_mask;
    return r;
  endfunction

  vgc_map_latch #(
    .MAPS(vgc_pkg::NUM_MAPS)
  ) u_latch (
    .sys_clk_in(sys_clk_in),
    .arst_n_in(arst_n_in),
    .load_in(latch_load),
    .data_in(map_rdata_in),
    .q_out(latch_q)
  );

  // Only host reads inside the window fill the latches
  // [RULE9] latch load
  assign latch_load = (cur.phase == ST_READ_WAIT) && map_rvalid_in;

  always_comb
  begin
    logic [17:0] win;
    logic [1:0] wmode;
    logic [1:0] fn;
    logic [2:0] rot;
    logic [7:0] rotated;
    logic [7:0] src;
    logic [7:0] mask;
    logic [7:0] res;
    logic [7:0] lat;
    logic [7:0] cmp;
    logic [1:0] plane;
    logic odd_even;
    win = '0;
    wmode = '0;
    fn = '0;
    rot = '0;
    rotated = '0;
    src = '0;
    mask = '0;
    res = '0;
    lat = '0;
    cmp = '0;
    plane = '0;
    odd_even = 1'b0;
    next_cur = cur;
    next_cur.io_rvalid = 1'b0;
    next_cur.mem_rvalid = 1'b0;
    next_cur.map_rd = 1'b0;
    next_cur.map_wr = 1'b0;

    // Register access through the index/data pair
    if (io_wr_in && io_addr_in == vgc_pkg::IO_INDEX_PORT)
    begin
      // [RULE1] index capture
      next_cur.register_pointer = io_wdata_in[3:0];
    end
    else if (io_wr_in && io_addr_in == vgc_pkg::IO_DATA_PORT)
    begin
      // [RULE18] unknown index dropped
      if (cur.register_pointer == vgc_pkg::IDX_SET_RESET_VALUE)
        // [RULE2] per-map constant
        next_cur.set_reset_value = io_wdata_in & vgc_pkg::MASK_NIBBLE;
      else if (cur.register_pointer == vgc_pkg::IDX_SET_RESET_ENABLE)
        next_cur.set_reset_enable = io_wdata_in & vgc_pkg::MASK_NIBBLE;
      else if (cur.register_pointer == vgc_pkg::IDX_COLOR_COMPARE)
        next_cur.color_compare = io_wdata_in & vgc_pkg::MASK_NIBBLE;
      else if (cur.register_pointer == vgc_pkg::IDX_DATA_ROTATE_FUNCTION)
        next_cur.data_rotate_function = io_wdata_in & vgc_pkg::MASK_ROTATE_FUNCTION;
      else if (cur.register_pointer == vgc_pkg::IDX_READ_MAP_SELECT)
        next_cur.read_map_select = io_wdata_in & vgc_pkg::MASK_READ_MAP;
      else if (cur.register_pointer == vgc_pkg::IDX_GRAPHICS_MODE)
        next_cur.graphics_mode = io_wdata_in & vgc_pkg::MASK_MODE;
      else if (cur.register_pointer == vgc_pkg::IDX_GRAPHICS_MISC)
        next_cur.graphics_misc = io_wdata_in & vgc_pkg::MASK_NIBBLE;
      else if (cur.register_pointer == vgc_pkg::IDX_COLOR_DONT_CARE)
        next_cur.color_dont_care = io_wdata_in & vgc_pkg::MASK_NIBBLE;
      else if (cur.register_pointer == vgc_pkg::IDX_WRITE_BIT_MASK)
        next_cur.write_bit_mask = io_wdata_in & vgc_pkg::MASK_FULL;
    end

    if (io_rd_in && io_addr_in == vgc_pkg::IO_INDEX_PORT)
    begin
      next_cur.io_rdata = {4'h0, cur.register_pointer};
      next_cur.io_rvalid = 1'b1;
    end
    else if (io_rd_in && io_addr_in == vgc_pkg::IO_DATA_PORT)
    begin
      // [RULE18] unknown index reads zero
      next_cur.io_rdata = reg_read(cur);
      next_cur.io_rvalid = 1'b1;
    end

    // [RULE14] packed overrides shift mode
    if (next_cur.graphics_mode[vgc_pkg::PACK_BIT])
      next_cur.shift_mode = vgc_pkg::SHIFT_PACKED;
    // [RULE13] linear or tiled
    else if (next_cur.graphics_mode[vgc_pkg::SHIFT_BIT])
      next_cur.shift_mode = vgc_pkg::SHIFT_TILED;
    else
      next_cur.shift_mode = vgc_pkg::SHIFT_LINEAR;

    // [RULE16] host window decode
    win = window_decode(mem_addr_in, cur.graphics_misc[vgc_pkg::WIN_LSB +: 2]);
    // [RULE12] odd/even addressing
    odd_even = cur.graphics_mode[vgc_pkg::ODD_EVEN_BIT] | cur.graphics_misc[vgc_pkg::CHAIN_BIT];
    // [RULE10] write mode select
    wmode = cur.graphics_mode[vgc_pkg::WMODE_LSB +: 2];
    fn = cur.data_rotate_function[vgc_pkg::FN_LSB +: 2];
    rot = cur.data_rotate_function[vgc_pkg::ROT_LSB +: 3];
    // [RULE6] rotate only in modes 0 and 3
    rotated = (wmode == vgc_pkg::WMODE_0 || wmode == vgc_pkg::WMODE_3) ? rotate_right(mem_wdata_in, rot) : mem_wdata_in;

    case (cur.phase)
      ST_IDLE:
      begin
        if (mem_wr_in && win[17])
        begin
          next_cur.map_wr = 1'b1;
          next_cur.map_addr = odd_even ? {win[ADDR_W-1:1], 1'b0} : win[ADDR_W-1:0];
          next_cur.map_wen = odd_even ? (win[0] ? 4'ha : 4'h5) : 4'hf;
          for (int i = 0; i < vgc_pkg::NUM_MAPS; i++)
          begin
            lat = latch_q[8*i +: 8];
            mask = cur.write_bit_mask;
            if (wmode == vgc_pkg::WMODE_2)
              src = {8{mem_wdata_in[i]}};
            else if (wmode == vgc_pkg::WMODE_3)
            begin
              src = {8{cur.set_reset_value[i]}};
              mask = cur.write_bit_mask & rotated;
            end
            // [RULE3] [RULE17] set/reset substitution
            else if (cur.set_reset_enable[i])
              src = {8{cur.set_reset_value[i]}};
            else
              src = rotated;
            // [RULE7] logical function
            res = logic_unit(src, lat, fn);
            // [RULE8] bit mask merge
            res = (res & mask) | (lat & ~mask);
            // Mode 1 copies latches, used for fast map-to-map moves
            next_cur.map_wdata[8*i +: 8] = (wmode == vgc_pkg::WMODE_1) ? lat : res;
          end
        end
        else if (mem_rd_in && win[17])
        begin
          next_cur.phase = ST_READ_WAIT;
          next_cur.busy = 1'b1;
          next_cur.map_rd = 1'b1;
          next_cur.odd_pending = win[0];
          next_cur.map_addr = odd_even ? {win[ADDR_W-1:1], 1'b0} : win[ADDR_W-1:0];
        end
        else if (mem_rd_in)
        begin
          // Outside the window answer at once so the host never hangs
          next_cur.mem_rdata = vgc_pkg::OUTSIDE_READ_DATA;
          next_cur.mem_rvalid = 1'b1;
        end
      end
      ST_READ_WAIT:
      begin
        if (map_rvalid_in)
        begin
          for (int b = 0; b < 8; b++)
          begin
            // [RULE4] [RULE5] masked color compare
            cmp[b] = ~|(({map_rdata_in[24 + b], map_rdata_in[16 + b], map_rdata_in[8 + b], map_rdata_in[b]}
              ^ cur.color_compare[3:0]) & cur.color_dont_care[3:0]);
          end
          plane = cur.read_map_select[1:0];
          if (odd_even)
            plane = {plane[1], cur.odd_pending};
          // [RULE11] read mode choice
          if (cur.graphics_mode[vgc_pkg::RMODE_BIT])
            next_cur.mem_rdata = cmp;
          else
            // [RULE9] byte read of selected map
            next_cur.mem_rdata = map_rdata_in[8*plane +: 8];
          next_cur.mem_rvalid = 1'b1;
          next_cur.busy = 1'b0;
          next_cur.phase = ST_IDLE;
        end
      end
      default:
      begin
        next_cur.phase = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      cur <= '0;
    end
    else
    begin
      cur <= next_cur;
    end
  end

  assign io_rdata_out = cur.io_rdata;
  assign io_rvalid_out = cur.io_rvalid;
  assign mem_rdata_out = cur.mem_rdata;
  assign mem_rvalid_out = cur.mem_rvalid;
  assign mem_busy_out = cur.busy;
  assign map_rd_out = cur.map_rd;
  assign map_wr_out = cur.map_wr;
  assign map_addr_out = cur.map_addr;
  assign map_wen_out = cur.map_wen;
  assign map_wdata_out = cur.map_wdata;
  // [RULE15] mode and chain outputs
  assign graphics_mode_select_out = cur.graphics_misc[vgc_pkg::GFX_BIT];
  assign chain_odd_to_even_out = cur.graphics_misc[vgc_pkg::CHAIN_BIT];
  assign legacy_odd_even_enable_out = cur.graphics_mode[vgc_pkg::ODD_EVEN_BIT];
  assign shift_load_mode_out = cur.shift_mode;
  assign memory_window_select_out = cur.graphics_misc[vgc_pkg::WIN_LSB +: 2];
endmodule
`default_nettype wire

/* File: verilog/vgc_map_latch.sv */
/*
  Four display-map latches, one byte per map, loaded together.
  Assumes data_in is valid while load_in is high.
*/
`timescale 1ns/100ps
`default_nettype none
module vgc_map_latch #(
  parameter int MAPS = vgc_pkg::NUM_MAPS
) (
  input wire logic sys_clk_in,
  input wire logic arst_n_in,
  input wire logic load_in,
  input wire logic [8*MAPS-1:0] data_in,
  output logic [8*MAPS-1:0] q_out
);
  typedef struct packed {
    logic [8*MAPS-1:0] bytes;
  } vgc_latch_state_t;

  vgc_latch_state_t cur;
  vgc_latch_state_t next_cur;

  always_comb
  begin
    next_cur = cur;
    if (load_in)
    begin
      next_cur.bytes = data_in;
    end
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      cur <= '0;
    end
    else
    begin
      cur <= next_cur;
    end
  end

  assign q_out = cur.bytes;
endmodule
`default_nettype wire
